// *** src/station_status_pkg.sv ***
// Constants shared by the station status word block
//------------------------------------------------------------
//------------------------------------------------------------
package station_status_pkg;

  // Register byte offsets
  localparam logic [7:0] status_word_off = 8'h00;
  localparam logic [7:0] irq_status_off = 8'h04;
  localparam logic [7:0] irq_clear_off = 8'h08;
  localparam logic [7:0] irq_enable_off = 8'h0c;

  // Field positions of the status word
  localparam int unsigned active_pos = 15;
  localparam int unsigned sim_pos = 14;
  localparam int unsigned fault_pos = 13;
  localparam int unsigned module_pos = 12;
  localparam int unsigned code_lsb = 8;
  localparam int unsigned multi_pos = 7;
  localparam int unsigned param_pos = 6;
  localparam int unsigned low_width = 6;

  // Error codes
  localparam logic [3:0] code_none = 4'h0;
  localparam logic [3:0] code_module = 4'h6;
  localparam logic [3:0] code_supply = 4'h7;
  localparam logic [3:0] code_reserved = 4'hf;

  // Interrupt event bits
  localparam int unsigned ev_fault_set = 0;
  localparam int unsigned ev_fault_clr = 1;
  localparam int unsigned ev_multi_set = 2;
  localparam int unsigned ev_active_chg = 3;
  localparam int unsigned ev_sim_chg = 4;
  localparam int unsigned ev_param_done = 5;
  localparam int unsigned ev_code_chg = 6;
  localparam int unsigned ev_width = 7;

  // Reset values
  localparam logic [15:0] status_word_rst = 16'h0000;
  localparam logic [ev_width-1:0] irq_rst = 7'h00;
  localparam logic [31:0] rdata_rst = 32'h0000_0000;

endpackage : station_status_pkg

// *** src/bit_sync.sv ***
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int unsigned width = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);

  logic [width-1:0] meta_ff;
  logic [width-1:0] sync_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : bit_sync

`default_nettype wire

// *** src/ones_count.sv ***
// Counts the set bits of a vector
`timescale 1ns/1ps
`default_nettype none

module ones_count #(
  parameter int unsigned width = 8,
  parameter int unsigned cnt_width = 4
) (
  input wire logic [width-1:0] vec,
  output logic [cnt_width-1:0] count
);

  logic [cnt_width-1:0] part [width+1];

  assign part[0] = '0;

  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_add
      assign part[i+1] = part[i] + cnt_width'(vec[i]);
    end
  endgenerate

  assign count = part[width];

endmodule : ones_count

`default_nettype wire

// *** src/station_status_word.sv ***
// Station status word with APB register access and interrupt
`timescale 1ns/1ps
`default_nettype none

module station_status_word #(
  parameter int unsigned num_slots = 32,
  parameter int unsigned num_supplies = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Station state, asynchronous levels
  input wire logic unit_active,
  input wire logic sim_active,
  input wire logic param_busy,
  input wire logic [15:0] err_req,
  input wire logic [num_slots-1:0] slot_fault,
  input wire logic [num_supplies-1:0] supply_fault,
  // Interrupt and word
  output logic irq,
  output logic [15:0] status_word
);

  localparam int unsigned n_in = 3 + 16 + num_slots + num_supplies;
  localparam int unsigned cnt_w = 8;
  localparam int unsigned n_cnt = 16 + num_slots + num_supplies;

  //------------------------------------------------------------
  // Input synchronisation
  //------------------------------------------------------------
  logic [n_in-1:0] raw_in;
  logic [n_in-1:0] sync_in;

  assign raw_in = {unit_active, sim_active, param_busy, err_req, slot_fault, supply_fault};

  bit_sync #(
    .width(n_in)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  logic active_s;
  logic sim_s;
  logic param_s;
  logic [15:0] err_s;
  logic [num_slots-1:0] slot_s;
  logic [num_supplies-1:0] supply_s;

  assign supply_s = sync_in[num_supplies-1:0];
  assign slot_s = sync_in[num_supplies +: num_slots];
  assign err_s = sync_in[num_supplies+num_slots +: 16];
  assign param_s = sync_in[n_in-3];
  assign sim_s = sync_in[n_in-2];
  assign active_s = sync_in[n_in-1];

  //------------------------------------------------------------
  // Fault sources
  //------------------------------------------------------------
  // Code 6 and 7 come from the slot and supply vectors; code 0 and the
  // reserved code F carry no request, so those request bits are ignored.
  logic [15:0] code_act;

  always_comb begin
    code_act = err_s;
    code_act[0] = 1'b0;
    code_act[station_status_pkg::code_module] = |slot_s;
    code_act[station_status_pkg::code_supply] = |supply_s;
    code_act[station_status_pkg::code_reserved] = 1'b0;
  end

  // Lowest code number wins as the highest priority fault
  logic [3:0] nxt_code;

  always_comb begin
    nxt_code = station_status_pkg::code_none;
    for (int k = 15; k >= 1; k--) begin
      if (code_act[k]) begin
        nxt_code = 4'(k);
      end
    end
  end

  //------------------------------------------------------------
  // Fault counting
  //------------------------------------------------------------
  // A general code counts once, each faulty slot and supply once
  logic [15:0] gen_only;
  logic [cnt_w-1:0] fault_cnt;

  always_comb begin
    gen_only = code_act;
    gen_only[station_status_pkg::code_module] = 1'b0;
    gen_only[station_status_pkg::code_supply] = 1'b0;
  end

  ones_count #(
    .width(n_cnt),
    .cnt_width(cnt_w)
  ) u_count (
    .vec({gen_only, slot_s, supply_s}),
    .count(fault_cnt)
  );

  function automatic int unsigned ones_supply(input logic [num_supplies-1:0] v);
    int unsigned n;
    n = 0;
    for (int j = 0; j < num_supplies; j++) begin
      n = n + int'(v[j]);
    end
    return n;
  endfunction : ones_supply

  logic any_fault;
  logic supply_only;

  assign any_fault = (nxt_code != station_status_pkg::code_none);
  // Supply-only means every counted fault sits in the supply vector
  assign supply_only = (nxt_code == station_status_pkg::code_supply)
      && (fault_cnt == cnt_w'(ones_supply(supply_s)));

  //------------------------------------------------------------
  // Slot number of the single faulty slot
  //------------------------------------------------------------
  logic [station_status_pkg::low_width-1:0] slot_num;

  // Lowest faulty slot wins, slot numbers start at one
  always_comb begin
    slot_num = '0;
    for (int s = num_slots - 1; s >= 0; s--) begin
      if (slot_s[s]) begin
        slot_num = station_status_pkg::low_width'(s + 1);
      end
    end
  end

  //------------------------------------------------------------
  // Word composition
  //------------------------------------------------------------
  logic nxt_multi;
  logic [station_status_pkg::low_width-1:0] nxt_low;
  logic [station_status_pkg::low_width-1:0] cnt_sat;
  logic [15:0] nxt_word;

  // A count that does not fit shows all ones
  assign cnt_sat = (fault_cnt > cnt_w'(6'h3f)) ? 6'h3f
      : fault_cnt[station_status_pkg::low_width-1:0];

  always_comb begin
    nxt_multi = 1'b0;
    nxt_low = '0;
    if (supply_only) begin
      nxt_multi = 1'b0;
      nxt_low = station_status_pkg::low_width'(supply_s);
    end else if (fault_cnt > cnt_w'(1)) begin
      nxt_multi = 1'b1;
      nxt_low = cnt_sat;
    end else if (nxt_code == station_status_pkg::code_module) begin
      nxt_low = slot_num;
    end
  end

  always_comb begin
    nxt_word = station_status_pkg::status_word_rst;
    nxt_word[station_status_pkg::active_pos] = active_s;
    nxt_word[station_status_pkg::sim_pos] = sim_s;
    nxt_word[station_status_pkg::fault_pos] = any_fault;
    nxt_word[station_status_pkg::module_pos] =
        (nxt_code == station_status_pkg::code_module);
    nxt_word[station_status_pkg::code_lsb +: 4] = nxt_code;
    nxt_word[station_status_pkg::multi_pos] = nxt_multi;
    nxt_word[station_status_pkg::param_pos] = param_s;
    nxt_word[station_status_pkg::low_width-1:0] = nxt_low;
  end

  logic [15:0] word_ff;

  // Refreshed every enabled cycle, nothing is held back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_ff <= station_status_pkg::status_word_rst;
    end else if (ce) begin
      word_ff <= nxt_word;
    end
  end

  assign status_word = word_ff;

  //------------------------------------------------------------
  // Events from word changes
  //------------------------------------------------------------
  logic [15:0] prev_ff;
  logic prev_valid_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= station_status_pkg::status_word_rst;
      prev_valid_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= word_ff;
      prev_valid_ff <= 1'b1;
    end
  end

  logic [station_status_pkg::ev_width-1:0] events;

  // The first enabled edge after reset only fills the history
  always_comb begin
    events = '0;
    if (prev_valid_ff) begin
      events[station_status_pkg::ev_fault_set] =
          word_ff[station_status_pkg::fault_pos] && !prev_ff[station_status_pkg::fault_pos];
      events[station_status_pkg::ev_fault_clr] =
          !word_ff[station_status_pkg::fault_pos] && prev_ff[station_status_pkg::fault_pos];
      events[station_status_pkg::ev_multi_set] =
          word_ff[station_status_pkg::multi_pos] && !prev_ff[station_status_pkg::multi_pos];
      events[station_status_pkg::ev_active_chg] =
          word_ff[station_status_pkg::active_pos] != prev_ff[station_status_pkg::active_pos];
      events[station_status_pkg::ev_sim_chg] =
          word_ff[station_status_pkg::sim_pos] != prev_ff[station_status_pkg::sim_pos];
      events[station_status_pkg::ev_param_done] =
          !word_ff[station_status_pkg::param_pos] && prev_ff[station_status_pkg::param_pos];
      events[station_status_pkg::ev_code_chg] =
          word_ff[station_status_pkg::code_lsb +: 4] != prev_ff[station_status_pkg::code_lsb +: 4];
    end
  end

  //------------------------------------------------------------
  // APB decode
  //------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic mapped;
  logic clear_wr;
  logic enable_wr;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_acc = access_ph && pwrite && ce;
  assign clear_wr = wr_acc && (paddr == station_status_pkg::irq_clear_off);
  assign enable_wr = wr_acc && (paddr == station_status_pkg::irq_enable_off);

  always_comb begin
    case (paddr)
      station_status_pkg::status_word_off: mapped = 1'b1;
      station_status_pkg::irq_status_off: mapped = 1'b1;
      station_status_pkg::irq_clear_off: mapped = 1'b1;
      station_status_pkg::irq_enable_off: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read data is loaded in the setup cycle, so the access cycle ends in its first cycle with ce high
  assign pready = ce;
  // Unmapped offsets flag an error and change no register
  assign pslverr = access_ph && !mapped;

  //------------------------------------------------------------
  // Interrupt registers
  //------------------------------------------------------------
  logic [station_status_pkg::ev_width-1:0] irq_stat_ff;
  logic [station_status_pkg::ev_width-1:0] irq_en_ff;
  logic [station_status_pkg::ev_width-1:0] clr_mask;
  logic [station_status_pkg::ev_width-1:0] nxt_irq_stat;

  assign clr_mask = clear_wr ? pwdata[station_status_pkg::ev_width-1:0] : '0;

  // A new event wins over a clear in the same cycle
  assign nxt_irq_stat = (irq_stat_ff & ~clr_mask) | events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= station_status_pkg::irq_rst;
    end else if (ce) begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // Enables mask the line only, events are always recorded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= station_status_pkg::irq_rst;
    end else if (enable_wr) begin
      irq_en_ff <= pwdata[station_status_pkg::ev_width-1:0];
    end
  end

  logic irq_ff;

  // The line follows the stored status on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  assign irq = irq_ff;

  //------------------------------------------------------------
  // Read data
  //------------------------------------------------------------
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;

  // The write-only clear register reads as zero
  always_comb begin
    nxt_rdata = station_status_pkg::rdata_rst;
    case (paddr)
      station_status_pkg::status_word_off: nxt_rdata[15:0] = word_ff;
      station_status_pkg::irq_status_off: nxt_rdata[station_status_pkg::ev_width-1:0] = irq_stat_ff;
      station_status_pkg::irq_enable_off: nxt_rdata[station_status_pkg::ev_width-1:0] = irq_en_ff;
      default: nxt_rdata = station_status_pkg::rdata_rst;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= station_status_pkg::rdata_rst;
    end else if (ce && setup_ph && !pwrite) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata = rdata_ff;

endmodule : station_status_word

`default_nettype wire

// *** verification/station_status_word_sva.sv ***
// Port checker for the station status word
`timescale 1ns/1ps
`default_nettype none

module station_status_word_sva #(
  parameter int unsigned num_slots = 32,
  parameter int unsigned num_supplies = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic unit_active,
  input wire logic sim_active,
  input wire logic param_busy,
  input wire logic [15:0] err_req,
  input wire logic [num_slots-1:0] slot_fault,
  input wire logic [num_supplies-1:0] supply_fault,
  input wire logic irq,
  input wire logic [15:0] status_word
);
  //------------------------------------------------------------
  // Helper logic
  //------------------------------------------------------------
  localparam logic [num_slots-1:0] one_slot = {{(num_slots - 1){1'b0}}, 1'b1};
  logic [1:0] en_cnt_ff;
  logic settled;

  // Counts enabled edges so the three-edge input path is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_cnt_ff <= 2'h0;
    end else if (!ce) begin
      en_cnt_ff <= 2'h0;
    end else if (en_cnt_ff != 2'h3) begin
      en_cnt_ff <= en_cnt_ff + 2'h1;
    end
  end
  assign settled = (en_cnt_ff == 2'h3);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  //------------------------------------------------------------
  // Properties
  //------------------------------------------------------------
  sequence s_rd_setup;
    psel && !penable && !pwrite && ce && paddr == station_status_pkg::status_word_off;
  endsequence
  sequence s_slot_only;
    settled && ($past(err_req, 3) & 16'h7f3e) == 16'h0000 && $past(supply_fault, 3) == '0;
  endsequence

  property p_active;
    settled |-> status_word[15] == $past(unit_active, 3);
  endproperty
  property p_sim;
    settled |-> status_word[14] == $past(sim_active, 3);
  endproperty
  property p_param;
    settled |-> status_word[6] == $past(param_busy, 3);
  endproperty
  property p_fault;
    status_word[13] == (status_word[11:8] != 4'h0) && status_word[12] == (status_word[11:8] == 4'h6);
  endproperty
  property p_no_rsv;
    status_word[11:8] != 4'hf;
  endproperty
  property p_supply;
    settled && ($past(err_req, 3) & 16'h7f3e) == 16'h0000 && $past(slot_fault, 3) == '0
      && $past(supply_fault, 3) != '0 |-> status_word[11:8] == 4'h7 && !status_word[7]
      && status_word[5:0] == $past(supply_fault, 3);
  endproperty
  property p_single;
    s_slot_only ##0 $onehot($past(slot_fault, 3)) |-> status_word[11:8] == 4'h6
      && !status_word[7] && $past(slot_fault, 3) == (one_slot << (status_word[5:0] - 6'h01));
  endproperty
  property p_multi;
    s_slot_only ##0 $countones($past(slot_fault, 3)) > 1 |-> status_word[7]
      && status_word[5:0] == 6'($countones($past(slot_fault, 3)));
  endproperty
  property p_read;
    s_rd_setup |=> prdata == {16'h0000, $past(status_word)};
  endproperty

  a_active: assert property (p_active) else $error("active bit wrong");
  a_sim: assert property (p_sim) else $error("simulation bit wrong");
  a_param: assert property (p_param) else $error("parameterization bit wrong");
  a_fault: assert property (p_fault) else $error("fault bits disagree with code");
  a_no_rsv: assert property (p_no_rsv) else $error("reserved code produced");
  a_supply: assert property (p_supply) else $error("supply bitmap wrong");
  a_single: assert property (p_single) else $error("slot number wrong");
  a_multi: assert property (p_multi) else $error("fault count wrong");
  a_read: assert property (p_read) else $error("read word wrong");
endmodule : station_status_word_sva

bind station_status_word station_status_word_sva #(
  .num_slots(num_slots), .num_supplies(num_supplies)
) u_station_status_word_sva (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .unit_active(unit_active), .sim_active(sim_active), .param_busy(param_busy),
  .err_req(err_req), .slot_fault(slot_fault), .supply_fault(supply_fault), .irq(irq),
  .status_word(status_word)
);

`default_nettype wire

// *** verification/test_station_status_word.sv ***
// Self-checking bench of the station status word
`timescale 1ns/1ps
`default_nettype none

module test_station_status_word;
  //------------------------------------------------------------
  // Signals and table
  //------------------------------------------------------------
  typedef struct packed {
    logic [2:0] f;
    logic [15:0] er;
    logic [31:0] sl;
    logic [5:0] su;
    logic [15:0] w;
  } row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic unit_active = 1'b0;
  logic sim_active = 1'b0;
  logic param_busy = 1'b0;
  logic [15:0] err_req = 16'h0000;
  logic [31:0] slot_fault = 32'h0;
  logic [5:0] supply_fault = 6'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [15:0] status_word;
  logic [31:0] rd;
  logic er_flag;
  int error_cnt = 0;
  int n_tests = 0;
  row_t rows [14] = '{
    '{3'b000, 16'h0000, 32'h0, 6'h00, 16'h0000}, '{3'b100, 16'h0000, 32'h0, 6'h00, 16'h8000},
    '{3'b011, 16'h0000, 32'h0, 6'h00, 16'h4040}, '{3'b100, 16'h0000, 32'h0, 6'h04, 16'ha704},
    '{3'b000, 16'h0000, 32'h0, 6'h21, 16'h2721}, '{3'b000, 16'h0000, 32'h8, 6'h00, 16'h3604},
    '{3'b000, 16'h0000, 32'h3, 6'h00, 16'h3682}, '{3'b000, 16'h0400, 32'h0, 6'h00, 16'h2a00},
    '{3'b000, 16'h0102, 32'h0, 6'h01, 16'h2183}, '{3'b000, 16'h4000, 32'h0, 6'h00, 16'h2e00},
    '{3'b000, 16'hffff, 32'h0, 6'h00, 16'h218c}, '{3'b111, 16'h0000, 32'h80000000, 6'h00, 16'hf660},
    '{3'b000, 16'h0000, 32'hffffffff, 6'h3f, 16'h36a6}, '{3'b000, 16'h80c1, 32'h0, 6'h00, 16'h0000}
  };

  station_status_word u_station_status_word (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unit_active(unit_active), .sim_active(sim_active), .param_busy(param_busy),
    .err_req(err_req), .slot_fault(slot_fault), .supply_fault(supply_fault), .irq(irq),
    .status_word(status_word)
  );

  always #2.5 pclk = ~pclk;

  //------------------------------------------------------------
  // Tasks
  //------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_d

  task automatic chk_b(input logic got, input logic exp);
    chk_d({31'h0, got}, {31'h0, exp});
  endtask : chk_b

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er_flag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out();
    end
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_d(rd, exp);
  endtask : rd_chk

  task automatic settle;
    repeat (4) @(posedge pclk);
  endtask : settle

  //------------------------------------------------------------
  // Sequence
  //------------------------------------------------------------
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'(i * 4), 32'h0);
    end
    $display("test reset values done");
    foreach (rows[i]) begin
      {unit_active, sim_active, param_busy} <= rows[i].f;
      err_req <= rows[i].er;
      slot_fault <= rows[i].sl;
      supply_fault <= rows[i].su;
      settle();
      chk_d({16'h0, status_word}, {16'h0, rows[i].w});
      rd_chk(station_status_pkg::status_word_off, {16'h0, rows[i].w});
    end
    $display("test table done");
    for (int k = 1; k < 16; k++) begin
      if (k == 6 || k == 7) continue;
      err_req <= 16'h0001 << k;
      settle();
      chk_d({16'h0, status_word}, (k == 15) ? 32'h0 : {16'h0, 4'h2, 4'(k), 8'h00});
    end
    $display("test codes done");
    err_req <= 16'h0000;
    unit_active <= 1'b1;
    ce <= 1'b0;
    settle();
    chk_d({16'h0, status_word}, 32'h0);
    chk_b(pready, 1'b0);
    ce <= 1'b1;
    settle();
    chk_d({16'h0, status_word}, 32'h8000);
    $display("test freeze done");
    apb(1'b1, station_status_pkg::irq_clear_off, 32'h7f);
    rd_chk(station_status_pkg::irq_status_off, 32'h0);
    apb(1'b1, station_status_pkg::irq_enable_off, 32'h01);
    rd_chk(station_status_pkg::irq_enable_off, 32'h01);
    slot_fault <= 32'h1;
    repeat (2) settle();
    chk_b(irq, 1'b1);
    rd_chk(station_status_pkg::irq_status_off, 32'h41);
    apb(1'b1, station_status_pkg::irq_enable_off, 32'h0);
    repeat (2) @(posedge pclk);
    chk_b(irq, 1'b0);
    apb(1'b1, station_status_pkg::irq_enable_off, 32'h01);
    apb(1'b1, station_status_pkg::irq_clear_off, 32'h01);
    repeat (2) @(posedge pclk);
    chk_b(irq, 1'b0);
    rd_chk(station_status_pkg::irq_status_off, 32'h40);
    rd_chk(station_status_pkg::irq_clear_off, 32'h0);
    $display("test interrupt done");
    apb(1'b0, 8'h10, 32'h0);
    chk_b(er_flag, 1'b1);
    chk_d(rd, 32'h0);
    apb(1'b1, station_status_pkg::status_word_off, 32'hffff);
    rd_chk(station_status_pkg::status_word_off, 32'hb601);
    apb(1'b1, station_status_pkg::irq_status_off, 32'h7f);
    rd_chk(station_status_pkg::irq_status_off, 32'h40);
    $display("test refusals done");
    apb(1'b1, station_status_pkg::irq_clear_off, 32'h7f);
    slot_fault <= 32'h3;
    sim_active <= 1'b1;
    param_busy <= 1'b1;
    settle();
    chk_d({16'h0, status_word}, 32'hf6c2);
    rd_chk(station_status_pkg::irq_status_off, 32'h14);
    slot_fault <= 32'h0;
    sim_active <= 1'b0;
    param_busy <= 1'b0;
    unit_active <= 1'b0;
    settle();
    rd_chk(station_status_pkg::irq_status_off, 32'h7e);
    apb(1'b1, station_status_pkg::irq_enable_off, 32'h02);
    repeat (2) @(posedge pclk);
    chk_b(irq, 1'b1);
    $display("test events done");
    presetn <= 1'b0;
    unit_active <= 1'b1;
    @(posedge pclk);
    #1;
    chk_d({16'h0, status_word}, 32'h0);
    chk_b(irq, 1'b0);
    chk_d(prdata, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk_d({16'h0, status_word}, 32'h8000);
    rd_chk(station_status_pkg::irq_enable_off, 32'h0);
    $display("test mid reset done");
    close_out();
  end
endmodule : test_station_status_word

`default_nettype wire
